/* logic/ca_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ca_link_if;
    logic        ck;
    logic        cs_n;
    logic [23:0] frame;
    logic        cke;
    logic        alert_n_o;
    logic        alert_n_oe;
    wire         alert_n = alert_n_oe ? alert_n_o : 1'b1;
    modport dram (input ck, input cs_n, input frame, input cke, output alert_n_o, output alert_n_oe);
    modport ctrl (output ck, output cs_n, output frame, output cke, input alert_n);
endinterface
`default_nettype wire

/* logic/ca_parity_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module ca_parity_ctrl
    import ca_parity_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    ca_link_if.ctrl          link,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    output logic             irq
);
    logic [7:0]  div_cnt;
    logic        ck_q;
    logic        fall_en;
    logic        pend;
    logic        cke_q;
    logic [23:0] cmd_frame;
    logic        cs_q;
    logic [23:0] frame_q;
    logic [1:0]  al_sync;
    logic        al_prev;
    logic [2:0]  status;
    logic [2:0]  mask;

    // The link clock is made here by division; chip select changes on its falling edge, frame and cke when REG_CMD is written.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            div_cnt <= 8'h00;
            ck_q    <= 1'b0;
        end else if (div_cnt == LINK_DIV - 8'h01) begin
            div_cnt <= 8'h00;
            ck_q    <= ~ck_q;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end
    assign fall_en = (div_cnt == LINK_DIV - 8'h01) && ck_q;
    assign link.ck = ck_q;

    // Parity is even: the parity bit makes the whole frame even unless wdata[24] asks for bad parity.
    always_comb begin
        cmd_frame            = wdata[23:0];
        cmd_frame[FRAME_PAR] = 1'b0;
        cmd_frame[FRAME_PAR] = (^cmd_frame) ^ wdata[24];
    end

    // While an alert is seen, only deselects go out.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pend    <= 1'b0;
            cs_q    <= 1'b1;
            frame_q <= 24'h000000;
            cke_q   <= 1'b1;
        end else begin
            if (wr && addr == REG_CMD && !pend) begin
                pend    <= 1'b1;
                cke_q   <= ~wdata[25];
                frame_q <= cmd_frame;
            end
            if (fall_en) begin
                cs_q <= 1'b1;
                if (pend && al_sync[1]) begin
                    cs_q <= 1'b0;
                    pend <= 1'b0;
                end
            end
        end
    end
    assign link.cs_n  = cs_q;
    assign link.frame = frame_q;
    assign link.cke   = cke_q;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            al_sync <= 2'h3;
            al_prev <= 1'b1;
        end else begin
            al_sync <= {al_sync[0], link.alert_n};
            al_prev <= al_sync[1];
        end
    end

    // Latency change passes through disabled is software's job.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status <= 3'h0;
            mask   <= 3'h0;
        end else begin
            if (wr && addr == REG_STATUS) status <= status & ~wdata[2:0];
            if (wr && addr == REG_MASK) mask <= wdata[2:0];
            if (al_prev && !al_sync[1]) status[ST_ALERT_SEEN] <= 1'b1;
            if (!al_prev && al_sync[1]) status[ST_ALERT_DONE] <= 1'b1;
            if (fall_en && pend && al_sync[1]) status[ST_CMD_SENT] <= 1'b1;
        end
    end
    assign irq = |(status & mask);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= 32'h00000000;
            if (rd) begin
                case (addr)
                    REG_STATUS: rdata <= {27'h0, ~al_sync[1], pend, status};
                    REG_MASK:   rdata <= {29'h0, mask};
                    default:    rdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* logic/ca_parity_dram.sv */
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ca_parity_dram
    import ca_parity_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    ca_link_if.dram          link,
    output logic      [23:0] exec_frame,
    output logic             exec_valid,
    output logic             precharge_all,
    output logic             pd_enter,
    output logic             irq
);
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_WAIT  = 2'b01,
        ST_ALERT = 2'b10
    } dram_state_t;

    dram_state_t state;
    logic [1:0]  ck_sync;
    logic        ck_prev;
    logic        cs_s1, cs_s2;
    logic [23:0] fr_s1, fr_s2;
    logic        cke_s1, cke_s2;
    logic        rise;
    logic [2:0]  lat_code;
    logic        err_stat;
    logic        persist;
    logic [23:0] err_log;
    logic        log_held;
    logic        irq_flag;
    logic [3:0]  lat_clk;
    logic [PIPE_DEPTH-1:0] pv;
    logic [23:0] pf [PIPE_DEPTH];
    logic        par_bad;
    logic [7:0]  tmr;
    logic        alert_q;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ck_sync <= 2'h0;
            ck_prev <= 1'b0;
            cs_s1   <= 1'b1;
            cs_s2   <= 1'b1;
            fr_s1   <= 24'h0;
            fr_s2   <= 24'h0;
            cke_s1  <= 1'b1;
            cke_s2  <= 1'b1;
        end else begin
            ck_sync <= {ck_sync[0], link.ck};
            ck_prev <= ck_sync[1];
            cs_s1   <= link.cs_n;
            cs_s2   <= cs_s1;
            fr_s1   <= link.frame;
            fr_s2   <= fr_s1;
            cke_s1  <= link.cke;
            cke_s2  <= cke_s1;
        end
    end
    assign rise = ck_sync[1] && !ck_prev;

    always_comb begin
        case (lat_code)
            LAT_4:   lat_clk = LAT_4_CLK;
            LAT_5:   lat_clk = LAT_5_CLK;
            LAT_6:   lat_clk = LAT_6_CLK;
            default: lat_clk = 4'h0;
        endcase
    end

    // Codes without a defined delay leave checking off as well, so a reserved code cannot raise alerts.
    assign par_bad = !cs_s2 && (lat_clk != 4'h0) && (^fr_s2)
                   && (persist || !err_stat) && (state == ST_RUN);

    // Commands shift one stage per link clock through PIPE_DEPTH stages; the output is taken from the stage whose index is the latency minus one.
    genvar g;
    generate
        for (g = 0; g < PIPE_DEPTH; g++) begin : g_pipe
            if (g == 0) begin : g_head
                // Nothing enters while the delay is zero; a mode write that turns the delay on would run twice.
                always_ff @(posedge clk_sys) begin
                    if (reset) begin
                        pv[g] <= 1'b0;
                        pf[g] <= 24'h0;
                    end else if (state != ST_RUN) begin
                        pv[g] <= 1'b0;
                    end else if (rise) begin
                        pv[g] <= !cs_s2 && !par_bad && (lat_clk != 4'h0);
                        pf[g] <= fr_s2;
                    end
                end
            end else begin : g_tail
                always_ff @(posedge clk_sys) begin
                    if (reset) begin
                        pv[g] <= 1'b0;
                        pf[g] <= 24'h0;
                    end else if (state != ST_RUN) begin
                        pv[g] <= 1'b0;
                    end else if (rise) begin
                        pv[g] <= pv[g-1];
                        pf[g] <= pf[g-1];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            exec_valid <= 1'b0;
            exec_frame <= 24'h0;
        end else begin
            exec_valid <= 1'b0;
            if (rise && state == ST_RUN) begin
                if (lat_clk == 4'h0) begin
                    exec_valid <= !cs_s2;
                    exec_frame <= fr_s2;
                end else begin
                    exec_valid <= pv[lat_clk[2:0] - 3'h1];
                    exec_frame <= pf[lat_clk[2:0] - 3'h1];
                end
            end
        end
    end

    // Mode bits; error status may only be written to zero by the controller.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lat_code <= LAT_OFF;
            persist  <= 1'b0;
            err_stat <= 1'b0;
        end else begin
            if (exec_valid && exec_frame[FRAME_ACT] && exec_frame[FRAME_BA0] && !exec_frame[FRAME_BA1]
                && !exec_frame[FRAME_A16] && !exec_frame[FRAME_A15] && !exec_frame[FRAME_A14]) begin
                lat_code <= exec_frame[MODE_LAT_LSB +: 3];
                persist  <= exec_frame[MODE_PERSIST_BIT];
                if (!exec_frame[MODE_ERR_BIT]) err_stat <= 1'b0;
            end
            if (par_bad) err_stat <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            err_log  <= 24'h0;
            log_held <= 1'b0;
        end else if (par_bad && !log_held) begin
            err_log  <= fr_s2;
            log_held <= 1'b1;
        end else if (!err_stat) begin
            log_held <= 1'b0;
        end
    end

    // Alert timing counts link rising edges so it follows the command clock.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state         <= ST_RUN;
            tmr           <= 8'h00;
            alert_q       <= 1'b0;
            precharge_all <= 1'b0;
            pd_enter      <= 1'b0;
        end else begin
            precharge_all <= 1'b0;
            pd_enter      <= 1'b0;
            case (state)
                ST_RUN: begin
                    if (par_bad) begin
                        state    <= ST_WAIT;
                        tmr      <= 8'h00;
                        pd_enter <= !fr_s2[FRAME_A16] && !fr_s2[FRAME_A15] && fr_s2[FRAME_A14]
                                    && !cke_s2;
                    end
                end
                ST_WAIT: begin
                    if (rise) tmr <= tmr + 8'h01;
                    if (tmr == ALERT_ON_LINK) begin
                        state         <= ST_ALERT;
                        tmr           <= 8'h00;
                        alert_q       <= 1'b1;
                        precharge_all <= 1'b1;
                    end
                end
                ST_ALERT: begin
                    if (rise) tmr <= tmr + 8'h01;
                    if (tmr == ALERT_PW_LINK) begin
                        state   <= ST_RUN;
                        alert_q <= 1'b0;
                    end
                end
                default: state <= ST_RUN;
            endcase
        end
    end
    assign link.alert_n_o  = 1'b0;
    assign link.alert_n_oe = alert_q;

    always_ff @(posedge clk_sys) begin
        if (reset) irq_flag <= 1'b0;
        else if (par_bad) irq_flag <= 1'b1;
        else if (!err_stat) irq_flag <= 1'b0;
    end
    assign irq = irq_flag;
endmodule
`default_nettype wire

/* logic/ca_parity_pkg.sv */
package ca_parity_pkg;
    localparam int        FRAME_W            = 24;
    localparam int        FRAME_ACT          = 23;
    localparam int        FRAME_BG0          = 22;
    localparam int        FRAME_BA1          = 21;
    localparam int        FRAME_BA0          = 20;
    localparam int        FRAME_A16          = 19;
    localparam int        FRAME_A15          = 18;
    localparam int        FRAME_A14          = 17;
    localparam int        FRAME_PAR          = 16;
    localparam int        FRAME_ADDR_HI      = 13;
    localparam logic [2:0] LAT_OFF           = 3'h0;
    localparam logic [2:0] LAT_4             = 3'h1;
    localparam logic [2:0] LAT_5             = 3'h2;
    localparam logic [2:0] LAT_6             = 3'h3;
    localparam logic [3:0] LAT_4_CLK         = 4'h4;
    localparam logic [3:0] LAT_5_CLK         = 4'h5;
    localparam logic [3:0] LAT_6_CLK         = 4'h6;
    localparam int        MODE_LAT_LSB       = 0;
    localparam int        MODE_ERR_BIT       = 4;
    localparam int        MODE_PERSIST_BIT   = 9;
    localparam int        PIPE_DEPTH         = 8;
    localparam logic [7:0] ALERT_ON_LINK     = 8'h02;
    localparam logic [7:0] ALERT_PW_LINK     = 8'h30;
    localparam logic [7:0] LINK_DIV          = 8'h05;
    localparam logic [3:0] REG_MODE          = 4'h0;
    localparam logic [3:0] REG_CMD           = 4'h1;
    localparam logic [3:0] REG_STATUS        = 4'h2;
    localparam logic [3:0] REG_MASK          = 4'h3;
    localparam logic [3:0] REG_LOG           = 4'h4;
    localparam int        ST_ALERT_SEEN      = 0;
    localparam int        ST_ALERT_DONE      = 1;
    localparam int        ST_CMD_SENT        = 2;
    localparam logic [2:0] CMD_SRE           = 3'h1;
endpackage

/* verif/ca_parity_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ca_parity_asserts
    import ca_parity_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        ck,
    input wire logic        cs_n,
    input wire logic [23:0] frame,
    input wire logic        cke,
    input wire logic        alert_n_o,
    input wire logic        alert_n_oe,
    input wire logic        alert_n
);
    // Alert may follow the parity delay, so the bound allows the longest delay plus the on-time.
    localparam int ON_MAX = 9;
    logic       ck_q;
    logic       rise;
    logic [7:0] low_cnt;
    logic [3:0] since;
    logic [3:0] ck_still;
    assign rise = ck && !ck_q;
    always_ff @(posedge clk_sys) begin
        ck_q <= ck;
    end
    always_ff @(posedge clk_sys) begin
        if (reset || alert_n) low_cnt <= 8'h00;
        else if (rise) low_cnt <= low_cnt + 8'h01;
    end
    always_ff @(posedge clk_sys) begin
        if (reset) since <= 4'hf;
        else if (rise && !cs_n) since <= 4'h0;
        else if (rise && since != 4'hf) since <= since + 4'h1;
    end
    // A stalled link clock would hide an alert caused by commands already sent.
    always_ff @(posedge clk_sys) begin
        if (reset || ck != ck_q) ck_still <= 4'h0;
        else if (ck_still != 4'hf) ck_still <= ck_still + 4'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    AST_ALERT_WIDTH: assert property ($rose(alert_n) |-> low_cnt >= ALERT_PW_LINK - 8'h01
        && low_cnt <= ALERT_PW_LINK + 8'h01) else $error("alert pulse width wrong");
    AST_ALERT_ON: assert property ($fell(alert_n) |-> since <= ON_MAX)
        else $error("alert came too late after command");
    AST_OPEN_DRAIN: assert property (alert_n_oe |-> !alert_n_o)
        else $error("alert line driven high");
    AST_DES_IN_ALERT: assert property (!alert_n |-> cs_n)
        else $error("command sent during alert");
    AST_CK_RUNS: assert property (ck_still < 4'ha)
        else $error("link clock stalled");
    AST_CS_ON_FALL: assert property ($fell(cs_n) |-> !ck)
        else $error("command not launched on falling edge");
    AST_CS_ONE_PERIOD: assert property ($fell(cs_n) |-> (!cs_n) [*8] ##[1:3] cs_n)
        else $error("chip select width wrong");
    AST_FRAME_HELD: assert property (!cs_n && !$past(cs_n) |-> $stable(frame))
        else $error("frame changed while selected");
    AST_IDLE_AFTER_RESET: assert property ($past(reset) |-> alert_n && cs_n && cke)
        else $error("link not idle after reset");
    cover property ($fell(alert_n));
    cover property ($rose(alert_n));
    cover property ($fell(cs_n) && !cke);
endmodule
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
    import ca_parity_pkg::*;
;
    localparam logic [23:0] F0 = 24'h0a1235;
    logic        clk_sys;
    logic        reset;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        irq_ctrl;
    logic [23:0] exec_frame;
    logic        exec_valid;
    logic        precharge_all;
    logic        pd_enter;
    logic        irq_dram;
    int          n_fail = 0;
    int          comparisons = 0;
    int          cyc = 0;
    ca_link_if link();
    ca_parity_ctrl u_ca_parity_ctrl (.clk_sys(clk_sys), .reset(reset), .link(link), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq_ctrl));
    ca_parity_dram u_ca_parity_dram (.clk_sys(clk_sys), .reset(reset), .link(link),
        .exec_frame(exec_frame), .exec_valid(exec_valid), .precharge_all(precharge_all),
        .pd_enter(pd_enter), .irq(irq_dram));
    ca_parity_asserts u_ca_parity_asserts (.clk_sys(clk_sys), .reset(reset), .ck(link.ck),
        .cs_n(link.cs_n), .frame(link.frame), .cke(link.cke), .alert_n_o(link.alert_n_o),
        .alert_n_oe(link.alert_n_oe), .alert_n(link.alert_n));
    always #2.5 clk_sys = ~clk_sys;
    task automatic test_done;
        if (n_fail == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            test_done;
        end
    end
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    function automatic logic [23:0] par(input logic [23:0] f);
        logic [23:0] g;
        g = f;
        g[FRAME_PAR] = ^{f[FRAME_ACT:FRAME_A14], f[FRAME_ADDR_HI:0]};
        return g;
    endfunction
    task automatic send(input logic [23:0] f, input logic bad, input logic cke_lo);
        wr_reg(REG_CMD, {6'h00, cke_lo, bad, par(f)});
    endtask
    // Watches the link until a command executes or an alert pulse has ended.
    task automatic run(output logic ex, output logic pre, output logic pd, output int low, output int lat);
        logic ckq;
        logic capt;
        logic was_low;
        ex = 1'b0;
        pre = 1'b0;
        pd = 1'b0;
        low = 0;
        lat = 0;
        capt = 1'b0;
        was_low = 1'b0;
        ckq = link.ck;
        for (int i = 0; i < 800; i++) begin
            @(posedge clk_sys);
            #1;
            if (link.ck && !ckq) begin
                if (!link.cs_n) capt = 1'b1;
                else if (capt) lat++;
                if (!link.alert_n) low++;
            end
            ckq = link.ck;
            ex = ex | (exec_valid === 1'b1);
            pre = pre | (precharge_all === 1'b1);
            pd = pd | (pd_enter === 1'b1);
            if (link.alert_n === 1'b0) was_low = 1'b1;
            if (ex || (was_low && link.alert_n === 1'b1)) break;
        end
    endtask
    task automatic mode(input logic [2:0] lat, input logic pers);
        logic [23:0] f;
        logic        ex, pre, pd;
        int          lo, la;
        f = 24'h900000;
        f[2:0] = lat;
        f[MODE_PERSIST_BIT] = pers;
        send(f, 1'b0, 1'b0);
        run(ex, pre, pd, lo, la);
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic t_latency;
        logic [2:0]  codes[4];
        logic [3:0]  clks[4];
        logic        ex, pre, pd;
        int          lo, la;
        logic [31:0] st;
        codes = '{LAT_OFF, LAT_4, LAT_5, LAT_6};
        clks = '{4'h0, LAT_4_CLK, LAT_5_CLK, LAT_6_CLK};
        for (int i = 0; i < 4; i++) begin
            mode(LAT_OFF, 1'b0);
            mode(codes[i], 1'b0);
            send(F0, 1'b0, 1'b0);
            run(ex, pre, pd, lo, la);
            chk(ex === 1'b1 && la == int'(clks[i]), "parity delay");
            chk(exec_frame === F0, "executed frame");
        end
        rd_reg(REG_STATUS, st);
        chk(st[ST_CMD_SENT] === 1'b1, "command sent flag");
        rd_reg(4'hf, st);
        chk(st === 32'h0, "unmapped read");
    endtask
    task automatic t_error;
        logic        ex, pre, pd;
        int          lo, la;
        logic [31:0] st;
        mode(LAT_OFF, 1'b0);
        mode(LAT_4, 1'b0);
        wr_reg(REG_MASK, 32'h1);
        wr_reg(REG_STATUS, 32'h7);
        send(F0, 1'b1, 1'b0);
        run(ex, pre, pd, lo, la);
        chk(ex === 1'b0 && pre === 1'b1, "errant command blocked");
        chk(lo >= 47, "alert width");
        chk(irq_dram === 1'b1 && irq_ctrl === 1'b1, "error flags");
        chk(u_ca_parity_dram.err_log === (F0 ^ (24'h000001 << FRAME_PAR)), "errant frame logged");
        // The alert release passes a synchroniser and an edge detector before it reaches the status.
        repeat (3) @(posedge clk_sys);
        rd_reg(REG_STATUS, st);
        chk(st[1:0] === 2'h3, "alert status");
        wr_reg(REG_STATUS, 32'h3);
        @(posedge clk_sys);
        #1;
        chk(irq_ctrl === 1'b0, "status cleared");
        send(F0, 1'b1, 1'b0);
        run(ex, pre, pd, lo, la);
        chk(ex === 1'b1 && lo == 0, "checking off");
        mode(LAT_4, 1'b0);
        chk(irq_dram === 1'b0, "error status clear");
        send(F0, 1'b1, 1'b0);
        run(ex, pre, pd, lo, la);
        chk(ex === 1'b0 && lo >= 47, "checking resumed");
        mode(LAT_4, 1'b0);
    endtask
    task automatic t_persist;
        logic ex, pre, pd;
        int   lo, la;
        mode(LAT_OFF, 1'b0);
        mode(LAT_4, 1'b1);
        wr_reg(REG_MASK, 32'h0);
        wr_reg(REG_STATUS, 32'h7);
        send(F0, 1'b1, 1'b0);
        run(ex, pre, pd, lo, la);
        chk(ex === 1'b0 && lo >= 47, "first error");
        chk(irq_ctrl === 1'b0, "masked interrupt");
        send(F0 ^ 24'h000001, 1'b1, 1'b0);
        run(ex, pre, pd, lo, la);
        chk(ex === 1'b0 && lo >= 47, "persistent checking");
        chk(u_ca_parity_dram.err_log === (F0 ^ (24'h000001 << FRAME_PAR)), "first error kept");
        mode(LAT_OFF, 1'b0);
    endtask
    task automatic t_sre;
        logic [23:0] f;
        logic        ex, pre, pd;
        int          lo, la;
        mode(LAT_4, 1'b0);
        f = 24'h800000;
        f[FRAME_A16:FRAME_A14] = CMD_SRE;
        send(f, 1'b1, 1'b1);
        run(ex, pre, pd, lo, la);
        chk(pd === 1'b1 && ex === 1'b0, "self refresh masked");
        mode(LAT_OFF, 1'b0);
    endtask
    initial begin
        clk_sys = 1'b0;
        reset = 1'b1;
        addr = 4'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        t_latency;
        t_error;
        t_persist;
        t_sre;
        test_done;
    end
endmodule
`default_nettype wire
